/* File: design/alin_linearizer.sv */
// angle linearizer: coefficient store, interpolating correction pipeline, axi4-lite registers
`timescale 1ns/1ns
`include "alin_map.svh"
module alin_linearizer import alin_pkg::*; #(
  parameter int N_COEF = `ALIN_N_COEF,
  parameter int WAKE_WIN_CYC = `ALIN_WAKE_WIN_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire alin_angle_t angle_in,
  input wire logic angle_in_valid,
  output alin_angle_t angle_out,
  output logic angle_out_valid,
  output alin_angle_t track_angle,
  output logic lp_awake
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  alin_coef_t coef_q [N_COEF];
  logic [2:0] ctrl_q, ctrl_d;
  logic [15:0] thr_q, thr_d;
  logic lin_en, ls_sel, lp_mode;

  assign lin_en = ctrl_q[`ALIN_CTRL_EN_BIT];
  assign ls_sel = ctrl_q[`ALIN_CTRL_LS_BIT];
  assign lp_mode = ctrl_q[`ALIN_CTRL_LP_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  logic aw_got_q, aw_got_d;
  logic w_got_q, w_got_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  alin_resp_t bresp_q, bresp_d;
  logic aw_now, w_now, do_wr;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic coef_we;
  logic [4:0] coef_wi;
  alin_coef_t coef_wd;

  function automatic logic [31:0] strb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : strb_merge

  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign aw_now = s_axi_awvalid && s_axi_awready;
  assign w_now = s_axi_wvalid && s_axi_wready;
  assign wa = aw_got_q ? awaddr_q : s_axi_awaddr;
  assign wd = w_got_q ? wdata_q : s_axi_wdata;
  assign ws = w_got_q ? wstrb_q : s_axi_wstrb;
  assign do_wr = (aw_got_q || aw_now) && (w_got_q || w_now);

  always_comb begin
    logic [31:0] merged;
    merged = 32'h00000000;
    aw_got_d = (aw_got_q || aw_now) && !do_wr;
    w_got_d = (w_got_q || w_now) && !do_wr;
    awaddr_d = aw_now ? s_axi_awaddr : awaddr_q;
    wdata_d = w_now ? s_axi_wdata : wdata_q;
    wstrb_d = w_now ? s_axi_wstrb : wstrb_q;
    bvalid_d = do_wr || (bvalid_q && !s_axi_bready);
    bresp_d = bresp_q;
    ctrl_d = ctrl_q;
    thr_d = thr_q;
    coef_we = 1'b0;
    coef_wi = wa[6:2];
    coef_wd = coef_q[wa[6:2]];
    if (do_wr) begin
      bresp_d = ALIN_RESP_OKAY;
      if (wa[7] == 1'b0) begin
        // user data may be stored here while correction is off
        merged = strb_merge({{20{coef_q[wa[6:2]][11]}}, coef_q[wa[6:2]]}, wd, ws);
        coef_we = 1'b1;
        coef_wd = merged[11:0];
      end else if ({wa[7:2], 2'b00} == `ALIN_CTRL_ADDR) begin
        merged = strb_merge({29'h0, ctrl_q}, wd, ws);
        ctrl_d = merged[2:0];
      end else if ({wa[7:2], 2'b00} == `ALIN_THR_ADDR) begin
        merged = strb_merge({16'h0000, thr_q}, wd, ws);
        thr_d = merged[15:0];
      end else if ({wa[7:2], 2'b00} != `ALIN_STAT_ADDR) begin
        bresp_d = ALIN_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= ALIN_RESP_OKAY;
      ctrl_q <= `ALIN_CTRL_RST;
      thr_q <= `ALIN_WAKE_THR_RST;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      ctrl_q <= ctrl_d;
      thr_q <= thr_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // one storage word per breakpoint
  for (genvar i = 0; i < N_COEF; i++) begin : g_coef
    alin_coef_t coef_d;
    assign coef_d = (coef_we && coef_wi == 5'(i)) ? coef_wd : coef_q[i];
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        coef_q[i] <= `ALIN_COEF_RST;
      end else begin
        coef_q[i] <= coef_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // correction pipeline, two stages in every mode

  logic s1_vld_q, s1_vld_d;
  alin_angle_t s1_ang_q, s1_ang_d;
  alin_coef_t s1_c0_q, s1_c0_d, s1_c1_q, s1_c1_d;
  logic [10:0] s1_frac_q, s1_frac_d;
  logic s1_en_q, s1_en_d, s1_ls_q, s1_ls_d;
  logic s2_vld_q, s2_vld_d;
  alin_angle_t s2_ang_q, s2_ang_d;
  alin_angle_t trk_q, trk_d;
  logic [4:0] idx0, idx1;
  logic signed [26:0] diff, interp, scaled, off;

  // index 31 pairs with index 0 by natural wrap
  assign idx0 = angle_in[15:11];
  assign idx1 = idx0 + 5'd1;

  assign diff = 27'(s1_c1_q) - 27'(s1_c0_q);
  assign interp = (27'(s1_c0_q) <<< 11) + 27'(diff * $signed({16'h0000, s1_frac_q}));
  assign scaled = s1_ls_q ? (interp <<< `ALIN_SHIFT_LS1) : (interp <<< `ALIN_SHIFT_LS0);
  assign off = scaled >>> `ALIN_FRAC_W;

  always_comb begin
    s1_vld_d = angle_in_valid;
    s1_ang_d = angle_in_valid ? angle_in : s1_ang_q;
    s1_c0_d = angle_in_valid ? coef_q[idx0] : s1_c0_q;
    s1_c1_d = angle_in_valid ? coef_q[idx1] : s1_c1_q;
    s1_frac_d = angle_in_valid ? angle_in[10:0] : s1_frac_q;
    s1_en_d = angle_in_valid ? lin_en : s1_en_q;
    s1_ls_d = angle_in_valid ? ls_sel : s1_ls_q;
    s2_vld_d = s1_vld_q;
    s2_ang_d = s2_ang_q;
    if (s1_vld_q) begin
      // modulo-one-revolution subtraction; disabled path stores the angle unchanged
      s2_ang_d = s1_en_q ? s1_ang_q - off[15:0] : s1_ang_q;
    end
    trk_d = angle_in_valid ? angle_in : trk_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_vld_q <= 1'b0;
      s1_ang_q <= 16'h0000;
      s1_c0_q <= 12'sh000;
      s1_c1_q <= 12'sh000;
      s1_frac_q <= 11'h000;
      s1_en_q <= 1'b0;
      s1_ls_q <= 1'b0;
      s2_vld_q <= 1'b0;
      s2_ang_q <= 16'h0000;
      trk_q <= 16'h0000;
    end else begin
      s1_vld_q <= s1_vld_d;
      s1_ang_q <= s1_ang_d;
      s1_c0_q <= s1_c0_d;
      s1_c1_q <= s1_c1_d;
      s1_frac_q <= s1_frac_d;
      s1_en_q <= s1_en_d;
      s1_ls_q <= s1_ls_d;
      s2_vld_q <= s2_vld_d;
      s2_ang_q <= s2_ang_d;
      trk_q <= trk_d;
    end
  end

  assign angle_out = s2_ang_q;
  assign angle_out_valid = s2_vld_q;
  assign track_angle = trk_q;

  ////////////////////////////////////////////////////////////////////////////
  // low-power wake on raw angle

  alin_wake_detect #(
    .WIN_CYC(WAKE_WIN_CYC)
  ) u_wake (
    .aclk(aclk),
    .aresetn(aresetn),
    .lp_mode(lp_mode),
    .raw_angle(angle_in),
    .raw_valid(angle_in_valid),
    .wake_thr(thr_q),
    .awake(lp_awake)
  );

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  alin_resp_t rresp_q, rresp_d;
  logic ar_now;

  assign s_axi_arready = !rvalid_q;
  assign ar_now = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rvalid_d = ar_now || (rvalid_q && !s_axi_rready);
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_now) begin
      rresp_d = ALIN_RESP_OKAY;
      rdata_d = 32'h00000000;
      if (s_axi_araddr[7] == 1'b0) begin
        rdata_d = {{20{coef_q[s_axi_araddr[6:2]][11]}}, coef_q[s_axi_araddr[6:2]]};
      end else if ({s_axi_araddr[7:2], 2'b00} == `ALIN_CTRL_ADDR) begin
        rdata_d = {29'h0, ctrl_q};
      end else if ({s_axi_araddr[7:2], 2'b00} == `ALIN_THR_ADDR) begin
        rdata_d = {16'h0000, thr_q};
      end else if ({s_axi_araddr[7:2], 2'b00} == `ALIN_STAT_ADDR) begin
        rdata_d = {s2_ang_q, 15'h0000, lp_awake};
      end else begin
        rresp_d = ALIN_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= ALIN_RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic signed [26:0] mid_ref;
  assign mid_ref = ((27'(s1_c0_q) + 27'(s1_c1_q)) <<< (s1_ls_q ? 2 : 1)) >>> 1;

  a_equal_latency: assert property (@(posedge aclk) disable iff (!aresetn)
    angle_in_valid |-> ##2 angle_out_valid)
    else $error("angle path latency is not two cycles");

  a_no_spurious: assert property (@(posedge aclk) disable iff (!aresetn)
    !angle_in_valid ##2 1'b1 |-> !angle_out_valid)
    else $error("output valid without an input two cycles earlier");

  a_bypass_raw: assert property (@(posedge aclk) disable iff (!aresetn)
    angle_in_valid && !lin_en |-> ##2 angle_out == $past(angle_in, 2))
    else $error("disabled correction altered the angle");

  a_breakpoint_sub: assert property (@(posedge aclk) disable iff (!aresetn)
    s1_vld_q && s1_en_q && s1_frac_q == 11'h000
    |=> angle_out == $past(s1_ang_q) - 16'(27'($past(s1_c0_q)) <<< ($past(s1_ls_q) ? 2 : 1)))
    else $error("breakpoint output is not angle minus coefficient");

  a_midpoint_avg: assert property (@(posedge aclk) disable iff (!aresetn)
    s1_vld_q && s1_frac_q == `ALIN_FRAC_MID |-> off == mid_ref)
    else $error("midpoint correction is not the coefficient average");

  a_scale_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    s1_vld_q |-> (off <= (s1_ls_q ? 27'sd8188 : 27'sd4094)) && (off >= (s1_ls_q ? -27'sd8192 : -27'sd4096)))
    else $error("correction exceeds the selected scale");

  a_wrap_pair: assert property (@(posedge aclk) disable iff (!aresetn)
    angle_in_valid && angle_in[15:11] == 5'h1F |=> s1_c1_q == $past(coef_q[0]) && s1_c0_q == $past(coef_q[31]))
    else $error("last segment does not pair last and first coefficient");

  a_coef_store: assert property (@(posedge aclk) disable iff (!aresetn)
    do_wr && wa[7] == 1'b0 && ws == 4'hF |=> coef_q[$past(wa[6:2])] == $past(wd[11:0]))
    else $error("coefficient write did not store twelve bits");

  a_track_raw: assert property (@(posedge aclk) disable iff (!aresetn)
    angle_in_valid |=> track_angle == $past(angle_in))
    else $error("tracking angle is not the raw angle");

  a_enable_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    angle_in_valid |=> s1_en_q == $past(lin_en))
    else $error("stored enable not applied to the sample");

endmodule : alin_linearizer

/* File: design/alin_map.svh */
// register map, field positions, reset values and timing counts of the angle linearizer
// Function
// - Thirty-two correction coefficients sit at breakpoints every 11.25 degrees, from 0.00 to 348.75 degrees.
// - At an exact breakpoint the output is the measured angle minus that breakpoint's coefficient.
// - Each coefficient is a 12-bit two's-complement value from -2048 to +2047.
// - The scale-select bit maps the coefficient range to 22.5 degrees when clear and 45 degrees when set.
// - Between breakpoints the correction is interpolated linearly, giving the average at the midpoint.
// - The angle path has the same pipeline depth whether correction is on or off.
// - With correction off the coefficients do not touch the angle and hold free user data.
// - The low-power tracking path works on the raw angle and skips correction.
// - In low-power mode the wake decision uses the rate of change of the raw angle only.
// - With the default wake rate the block stays awake while rotation exceeds 100 RPM.
`ifndef ALIN_MAP_SVH
`define ALIN_MAP_SVH

`define ALIN_ANGLE_W 16
`define ALIN_COEF_W 12
`define ALIN_N_COEF 32
`define ALIN_IDX_W 5
`define ALIN_FRAC_W 11
`define ALIN_FRAC_MID 11'h400

`define ALIN_ADDR_W 8
`define ALIN_COEF_BASE 8'h00
`define ALIN_CTRL_ADDR 8'h80
`define ALIN_THR_ADDR 8'h84
`define ALIN_STAT_ADDR 8'h88

`define ALIN_CTRL_EN_BIT 0
`define ALIN_CTRL_LS_BIT 1
`define ALIN_CTRL_LP_BIT 2
`define ALIN_CTRL_RST 3'h0
`define ALIN_COEF_RST 12'h000

`define ALIN_SHIFT_LS0 1
`define ALIN_SHIFT_LS1 2

`define ALIN_CLK_MHZ 50
`define ALIN_WAKE_WIN_US 1000
`define ALIN_WAKE_WIN_CYC (`ALIN_WAKE_WIN_US * `ALIN_CLK_MHZ)
// 100 rpm = 600 deg/s = 0.6 deg per 1 ms window = 109 angle units
`define ALIN_WAKE_THR_RST 16'h006D

`endif

/* File: design/alin_pkg.sv */
// types shared by the angle linearizer files
package alin_pkg;
  typedef logic [15:0] alin_angle_t;
  typedef logic signed [11:0] alin_coef_t;
  typedef enum logic [1:0] {
    ALIN_RESP_OKAY = 2'b00,
    ALIN_RESP_SLVERR = 2'b10
  } alin_resp_t;
endpackage : alin_pkg

/* File: design/alin_wake_detect.sv */
// low-power wake detector working on the raw angle
`timescale 1ns/1ns
`include "alin_map.svh"
module alin_wake_detect import alin_pkg::*; #(
  parameter int WIN_CYC = `ALIN_WAKE_WIN_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic lp_mode,
  input wire alin_angle_t raw_angle,
  input wire logic raw_valid,
  input wire logic [15:0] wake_thr,
  output logic awake
);
  localparam int CW = $clog2(WIN_CYC + 1);

  logic [CW-1:0] cnt_q, cnt_d;
  alin_angle_t ref_q, ref_d;
  alin_angle_t last_q, last_d;
  logic awake_q, awake_d;
  logic win_end;
  logic signed [15:0] delta;
  logic [15:0] mag;

  assign win_end = (cnt_q == CW'(WIN_CYC - 1));
  // wrap-aware change over the window
  assign delta = $signed(last_q - ref_q);
  assign mag = delta[15] ? 16'(-delta) : 16'(delta);

  always_comb begin
    cnt_d = win_end ? '0 : cnt_q + 1'b1;
    last_d = raw_valid ? raw_angle : last_q;
    ref_d = win_end ? last_q : ref_q;
    awake_d = awake_q;
    if (!lp_mode) begin
      awake_d = 1'b1;
    end else if (win_end) begin
      awake_d = (mag > wake_thr);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      ref_q <= 16'h0000;
      last_q <= 16'h0000;
      awake_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      ref_q <= ref_d;
      last_q <= last_d;
      awake_q <= awake_d;
    end
  end

  assign awake = awake_q;

  a_wake_decide: assert property (@(posedge aclk) disable iff (!aresetn)
    lp_mode && win_end |=> awake == ($past(mag) > $past(wake_thr)))
    else $error("wake decision does not follow raw angle change");

  a_wake_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    lp_mode && !win_end ##1 lp_mode |-> $stable(awake))
    else $error("wake level changed inside a window");
endmodule : alin_wake_detect

/* File: verification/alin_linearizer_tb.sv */
// self-checking bench for the angle linearizer
`timescale 1ns/1ns
`include "alin_map.svh"
module alin_linearizer_tb import alin_pkg::*;;
  localparam int WIN = 16;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  alin_angle_t angle_in = 16'h0000;
  logic angle_in_valid = 1'b0;
  alin_angle_t angle_out;
  logic angle_out_valid;
  alin_angle_t track_angle;
  logic lp_awake;
  int failures = 0;
  int check_count = 0;
  int coef_m[32];
  logic [31:0] rd;
  logic [1:0] rs;
  logic [2:0] modes[3] = '{3'h0, 3'h1, 3'h3};

  always #10 aclk = ~aclk;

  alin_linearizer #(.WAKE_WIN_CYC(WIN)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .angle_in(angle_in), .angle_in_valid(angle_in_valid), .angle_out(angle_out),
    .angle_out_valid(angle_out_valid), .track_angle(track_angle), .lp_awake(lp_awake)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic hang(input string what);
    failures++;
    $display("[FAIL] %s expected answer seen none", what);
    test_done();
  endtask : hang

  // both channels offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) hang("bvalid");
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) hang("rvalid");
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  function automatic alin_angle_t lin_exp(input alin_angle_t a, input logic [2:0] ctrl);
    longint c0;
    longint c1;
    longint t;
    c0 = coef_m[a[15:11]];
    c1 = coef_m[(int'(a[15:11]) + 1) % 32];
    t = (c0 * 2048 + (c1 - c0) * longint'(a[10:0])) <<< (ctrl[1] ? 2 : 1);
    t = t >>> 11;
    return ctrl[0] ? a - t[15:0] : a;
  endfunction : lin_exp

  // one sample, then the fixed two-cycle answer
  task automatic sample(input alin_angle_t a, input alin_angle_t exp);
    @(posedge aclk);
    angle_in <= a;
    angle_in_valid <= 1'b1;
    @(posedge aclk);
    angle_in_valid <= 1'b0;
    #1;
    chk("track_angle", 32'(track_angle), 32'(a));
    chk("early valid", 32'(angle_out_valid), 32'h0);
    @(posedge aclk);
    #1;
    chk("angle_out_valid", 32'(angle_out_valid), 32'h1);
    chk("angle_out", 32'(angle_out), 32'(exp));
  endtask : sample

  task automatic stream(input int step, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      angle_in <= angle_in + 16'(step);
      angle_in_valid <= 1'b1;
    end
    @(posedge aclk);
    angle_in_valid <= 1'b0;
    #1;
  endtask : stream

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk("lp_awake reset", 32'(lp_awake), 32'h1);
    chk("angle_out reset", 32'(angle_out), 32'h0);
    axi_rd(`ALIN_CTRL_ADDR, rd, rs);
    chk("ctrl reset", rd, 32'h0);
    axi_rd(`ALIN_THR_ADDR, rd, rs);
    chk("thr reset", rd, 32'h0000006D);
    axi_rd(8'h14, rd, rs);
    chk("coef reset", rd, 32'h0);
    axi_rd(8'h8C, rd, rs);
    chk("unmapped read", 32'(rs), 32'(ALIN_RESP_SLVERR));
    axi_wr(8'h90, 32'h1, rs);
    chk("unmapped write", 32'(rs), 32'(ALIN_RESP_SLVERR));
    $display("test reset_and_map done");
    // full range patterns, upper bits of the word are junk
    for (int i = 0; i < 32; i++) begin
      coef_m[i] = (i * 731) % 4096 - 2048;
      if (i == 0) coef_m[i] = 2047;
      if (i == 31) coef_m[i] = -2048;
      axi_wr(8'(i * 4), {20'hA5A5A, 12'(coef_m[i])}, rs);
      chk("coef write", 32'(rs), 32'(ALIN_RESP_OKAY));
    end
    axi_rd(8'h7C, rd, rs);
    chk("coef min", rd, 32'hFFFFF800);
    axi_rd(8'h00, rd, rs);
    chk("coef max", rd, 32'h000007FF);
    $display("test coef_store done");
    foreach (modes[m]) begin
      axi_wr(`ALIN_CTRL_ADDR, 32'(modes[m]), rs);
      for (int i = 0; i < 32; i++) begin
        sample(16'(i * 2048), lin_exp(16'(i * 2048), modes[m]));
        sample(16'(i * 2048 + 1024), lin_exp(16'(i * 2048 + 1024), modes[m]));
      end
      sample(16'hFFFF, lin_exp(16'hFFFF, modes[m]));
      $display("test angle_mode %0d done", modes[m]);
    end
    axi_rd(`ALIN_STAT_ADDR, rd, rs);
    chk("status", rd, {lin_exp(16'hFFFF, 3'h3), 15'h0, 1'b1});
    axi_wr(`ALIN_STAT_ADDR, 32'h0, rs);
    chk("status write", 32'(rs), 32'(ALIN_RESP_OKAY));
    // low-power wake from the raw angle rate
    axi_wr(`ALIN_CTRL_ADDR, 32'h5, rs);
    stream(0, 4 * WIN);
    chk("still asleep", 32'(lp_awake), 32'h0);
    stream(40, 4 * WIN);
    chk("moving awake", 32'(lp_awake), 32'h1);
    axi_wr(`ALIN_THR_ADDR, 32'h00000400, rs);
    stream(40, 4 * WIN);
    chk("high threshold", 32'(lp_awake), 32'h0);
    $display("test wake done");
    test_done();
  end
endmodule : alin_linearizer_tb
